// ===== src/omc_pkg.sv
package omc_pkg;

    // ---------------------------------------------------------------
    // timing
    // ---------------------------------------------------------------
    localparam int unsigned CLK_MHZ      = 200;
    localparam int unsigned STAB_TIME_US = 5000;
    localparam int unsigned STAB_CYCLES  = STAB_TIME_US * CLK_MHZ;

    // ---------------------------------------------------------------
    // sizes
    // ---------------------------------------------------------------
    localparam int unsigned WAKE_LINES = 16;
    localparam int unsigned DIV_W      = 4;
    localparam int unsigned WDG_W      = 16;
    localparam int unsigned ADR_W      = 8;

    // ---------------------------------------------------------------
    // register offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STOP   = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_WDG    = 8'h0C;
    localparam logic [7:0] ADDR_WAKE   = 8'h10;

    // ---------------------------------------------------------------
    // field positions and reset values
    // ---------------------------------------------------------------
    localparam int unsigned CTRL_SLOW_BIT = 0;
    localparam int unsigned CTRL_PLL_BIT  = 1;
    localparam int unsigned CTRL_WDG_BIT  = 2;
    localparam int unsigned CTRL_DIV_LSB  = 8;
    localparam int unsigned STOP_REQ_BIT  = 0;
    localparam int unsigned STAT_BUSY_BIT = 3;
    localparam int unsigned STAT_PLL_BIT  = 4;
    localparam int unsigned STAT_NMI_BIT  = 5;
    localparam logic [31:0] CTRL_RST      = 32'h0000_0102;
    localparam logic [31:0] CTRL_WMASK    = 32'h0000_0F07;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [2:0] {
        OMC_RUN  = 3'b000,
        OMC_WFI  = 3'b001,
        OMC_STOP = 3'b010,
        OMC_STAB = 3'b011,
        OMC_HALT = 3'b100
    } omc_state_t;

    typedef enum logic [1:0] {
        OMC_SEQ_IDLE = 2'b00,
        OMC_SEQ_ONE  = 2'b01,
        OMC_SEQ_ZERO = 2'b10
    } omc_seq_t;

    typedef struct packed {
        logic cpu;
        logic per;
    } omc_clk_en_t;

endpackage

// ===== src/omc_clk_div.sv
`timescale 1ns/1ps
module omc_clk_div #(
    parameter int unsigned W = 4
) (
    // clock and reset
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    // control
    input  wire logic         slow_i,
    input  wire logic [W-1:0] ratio_i,
    // enable pulse
    output logic              tick_o
);

    logic [W-1:0] cnt_ff;
    logic [W-1:0] nxt_cnt;
    logic         tick_ff;
    logic         nxt_tick;

    // ---------------------------------------------------------------
    // divide by ratio+1 in slow clocking, full rate otherwise
    // ---------------------------------------------------------------
    always_comb begin
        nxt_tick = !slow_i || (cnt_ff == ratio_i);
        nxt_cnt  = nxt_tick ? '0 : cnt_ff + W'(1);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt_ff  <= '0;
            tick_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            tick_ff <= nxt_tick;
        end
    end

    assign tick_o = tick_ff;

endmodule

// ===== src/omc_stab_cnt.sv
`timescale 1ns/1ps
module omc_stab_cnt #(
    parameter int unsigned CYCLES = omc_pkg::STAB_CYCLES
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // control
    input  wire logic start_i,
    input  wire logic osc_ok_i,
    // status
    output logic      busy_o,
    output logic      done_o
);

    localparam int unsigned CW = $clog2(CYCLES + 1);

    logic          busy_ff;
    logic          run_ff;
    logic          done_ff;
    logic [CW-1:0] cnt_ff;
    logic          nxt_busy;
    logic          nxt_run;
    logic          nxt_done;
    logic [CW-1:0] nxt_cnt;

    // ---------------------------------------------------------------
    // count only once the oscillator is seen running
    // ---------------------------------------------------------------
    always_comb begin
        nxt_busy = busy_ff;
        nxt_run  = run_ff;
        nxt_done = 1'b0;
        nxt_cnt  = cnt_ff;
        if (start_i) begin
            nxt_busy = 1'b1;
            nxt_run  = 1'b0;
            nxt_cnt  = '0;
        end else if (busy_ff) begin
            if (!run_ff) begin
                nxt_run = osc_ok_i; // R10
            end else if (cnt_ff == CW'(CYCLES - 1)) begin
                nxt_busy = 1'b0;
                nxt_run  = 1'b0;
                nxt_done = 1'b1;
            end else begin
                nxt_cnt = cnt_ff + CW'(1);
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_ff <= 1'b0;
            run_ff  <= 1'b0;
            done_ff <= 1'b0;
            cnt_ff  <= '0;
        end else begin
            busy_ff <= nxt_busy;
            run_ff  <= nxt_run;
            done_ff <= nxt_done;
            cnt_ff  <= nxt_cnt;
        end
    end

    assign busy_o = busy_ff;
    assign done_o = done_ff;

endmodule

// ===== src/omc_top.sv
// Functional notes
// R01: run mode clocks everything at PLL rate
// R02: slow mode clocks through prescaler divider
// R03: wait state suspends until interrupt acknowledged
// R04: wait state stops CPU, peripherals keep clocking
// R05: low-power wait uses slow rate while waiting
// R06: stop needs write sequence with NMI low
// R07: any wake-up line or NMI ends stop
// R08: state kept in stop, no reset on exit
// R09: watchdog count frozen during stop
// R10: stabilisation count after oscillator restarts
// R11: PLL deselected on stop exit, software reselects
// R12: halt without watchdog stops all clocks
// R13: only system reset leaves halt
// R14: halt with watchdog enabled is ignored
`timescale 1ns/1ps
module omc_top #(
    parameter int unsigned STAB_CYCLES = omc_pkg::STAB_CYCLES,
    parameter int unsigned WAKE_LINES  = omc_pkg::WAKE_LINES,
    parameter int unsigned WDG_W       = omc_pkg::WDG_W
) (
    // clock and reset
    input  wire logic                      clk_i,
    input  wire logic                      rst_i,
    // wishbone slave
    input  wire logic                      wb_cyc_i,
    input  wire logic                      wb_stb_i,
    input  wire logic                      wb_we_i,
    input  wire logic [omc_pkg::ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]                wb_sel_i,
    input  wire logic [31:0]               wb_dat_i,
    output logic [31:0]                    wb_dat_o,
    output logic                           wb_ack_o,
    // cpu events
    input  wire logic                      wfi_exec_i,
    input  wire logic                      halt_exec_i,
    input  wire logic                      irq_ack_i,
    // wake sources and oscillator
    input  wire logic                      nmi_i,
    input  wire logic [WAKE_LINES-1:0]     wakeup_line_i,
    input  wire logic                      osc_running_i,
    // clock control
    output omc_pkg::omc_clk_en_t           clk_en_o,
    output logic                           osc_stop_o,
    output logic                           pll_sel_o
);

    localparam int unsigned DW = omc_pkg::DIV_W;

    // ---------------------------------------------------------------
    // declarations
    // ---------------------------------------------------------------
    omc_pkg::omc_state_t   state_ff;
    omc_pkg::omc_state_t   nxt_state;
    omc_pkg::omc_seq_t     seq_ff;
    omc_pkg::omc_seq_t     nxt_seq;
    omc_pkg::omc_clk_en_t  clk_en_ff;
    omc_pkg::omc_clk_en_t  nxt_clk_en;
    logic [31:0]           ctrl_ff;
    logic [31:0]           nxt_ctrl;
    logic [WAKE_LINES-1:0] wake_ff;
    logic [WAKE_LINES-1:0] nxt_wake;
    logic [WDG_W-1:0]      wdg_ff;
    logic [WDG_W-1:0]      nxt_wdg;
    logic [31:0]           rdat_ff;
    logic [31:0]           nxt_rdat;
    logic                  ack_ff;
    logic                  nxt_ack;
    logic                  osc_stop_ff;
    logic                  nxt_osc_stop;
    logic                  pll_sel_ff;
    logic                  nxt_pll_sel;
    logic                  req;
    logic                  wr;
    logic [31:0]           wmask;
    logic                  stop_go;
    logic                  stop_exit;
    logic                  tick;
    logic                  stab_busy;
    logic                  stab_done;

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    function automatic logic hit(input logic [omc_pkg::ADR_W-1:0] adr,
                                 input logic [7:0] off);
        hit = (adr == off);
    endfunction

    function automatic logic [31:0] lanes(input logic [3:0] sel);
        lanes = {{8{sel[3]}}, {8{sel[2]}}, {8{sel[1]}}, {8{sel[0]}}};
    endfunction

    // ---------------------------------------------------------------
    // prescaler and stabilisation counter
    // ---------------------------------------------------------------
    omc_clk_div #(
        .W (DW)
    ) u_div (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .slow_i  (ctrl_ff[omc_pkg::CTRL_SLOW_BIT]),
        .ratio_i (ctrl_ff[omc_pkg::CTRL_DIV_LSB +: DW]),
        .tick_o  (tick)
    );

    omc_stab_cnt #(
        .CYCLES (STAB_CYCLES)
    ) u_stab (
        .clk_i    (clk_i),
        .rst_i    (rst_i),
        .start_i  (stop_exit),
        .osc_ok_i (osc_running_i),
        .busy_o   (stab_busy),
        .done_o   (stab_done)
    );

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    assign req   = wb_cyc_i && wb_stb_i && !ack_ff;
    assign wr    = req && wb_we_i;
    assign wmask = lanes(wb_sel_i);

    // ---------------------------------------------------------------
    // stop write sequence: 1, 0, 1 on the stop bit
    // ---------------------------------------------------------------
    always_comb begin
        nxt_seq = seq_ff;
        stop_go = 1'b0;
        if (wr && hit(wb_adr_i, omc_pkg::ADDR_STOP) && wb_sel_i[0]) begin
            case (seq_ff)
                omc_pkg::OMC_SEQ_IDLE: begin
                    nxt_seq = wb_dat_i[omc_pkg::STOP_REQ_BIT] ? omc_pkg::OMC_SEQ_ONE : omc_pkg::OMC_SEQ_IDLE;
                end
                omc_pkg::OMC_SEQ_ONE: begin
                    nxt_seq = wb_dat_i[omc_pkg::STOP_REQ_BIT] ? omc_pkg::OMC_SEQ_ONE : omc_pkg::OMC_SEQ_ZERO;
                end
                omc_pkg::OMC_SEQ_ZERO: begin
                    nxt_seq = omc_pkg::OMC_SEQ_IDLE;
                    stop_go = wb_dat_i[omc_pkg::STOP_REQ_BIT] && !nmi_i; // R06
                end
                default: begin
                    nxt_seq = omc_pkg::OMC_SEQ_IDLE;
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_comb begin
        nxt_ctrl = ctrl_ff;
        if (wr && hit(wb_adr_i, omc_pkg::ADDR_CTRL)) begin
            nxt_ctrl = (ctrl_ff & ~(wmask & omc_pkg::CTRL_WMASK)) |
                       (wb_dat_i & wmask & omc_pkg::CTRL_WMASK);
        end
        if (stop_exit) begin
            nxt_ctrl[omc_pkg::CTRL_PLL_BIT] = 1'b0; // R11
        end

        // sticky wake sources, set wins over clear
        nxt_wake = wake_ff;
        if (wr && hit(wb_adr_i, omc_pkg::ADDR_WAKE)) begin
            nxt_wake = wake_ff & ~(wb_dat_i[WAKE_LINES-1:0] & wmask[WAKE_LINES-1:0]);
        end
        if (state_ff == omc_pkg::OMC_STOP) begin
            nxt_wake = nxt_wake | wakeup_line_i;
        end

        // watchdog frozen outside running states
        nxt_wdg = wdg_ff;
        if (ctrl_ff[omc_pkg::CTRL_WDG_BIT] && tick &&
            (state_ff == omc_pkg::OMC_RUN || state_ff == omc_pkg::OMC_WFI)) begin
            nxt_wdg = wdg_ff + WDG_W'(1); // R09
        end

        nxt_ack  = req;
        nxt_rdat = rdat_ff;
        if (req && !wb_we_i) begin
            nxt_rdat = 32'h0000_0000;
            if (hit(wb_adr_i, omc_pkg::ADDR_CTRL)) begin
                nxt_rdat = ctrl_ff;
            end else if (hit(wb_adr_i, omc_pkg::ADDR_STOP)) begin
                nxt_rdat[1:0] = seq_ff;
            end else if (hit(wb_adr_i, omc_pkg::ADDR_STATUS)) begin
                nxt_rdat[2:0]                    = state_ff;
                nxt_rdat[omc_pkg::STAT_BUSY_BIT] = stab_busy;
                nxt_rdat[omc_pkg::STAT_PLL_BIT]  = pll_sel_ff;
                nxt_rdat[omc_pkg::STAT_NMI_BIT]  = nmi_i;
            end else if (hit(wb_adr_i, omc_pkg::ADDR_WDG)) begin
                nxt_rdat[WDG_W-1:0] = wdg_ff;
            end else if (hit(wb_adr_i, omc_pkg::ADDR_WAKE)) begin
                nxt_rdat[WAKE_LINES-1:0] = wake_ff;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_ff <= omc_pkg::CTRL_RST;
            seq_ff  <= omc_pkg::OMC_SEQ_IDLE;
            wake_ff <= '0;
            wdg_ff  <= '0;
            ack_ff  <= 1'b0;
            rdat_ff <= 32'h0000_0000;
        end else begin
            ctrl_ff <= nxt_ctrl;
            seq_ff  <= nxt_seq;
            wake_ff <= nxt_wake;
            wdg_ff  <= nxt_wdg;
            ack_ff  <= nxt_ack;
            rdat_ff <= nxt_rdat;
        end
    end

    // ---------------------------------------------------------------
    // operating mode state machine
    // ---------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        stop_exit = 1'b0;
        case (state_ff)
            omc_pkg::OMC_RUN: begin
                if (stop_go) begin
                    nxt_state = omc_pkg::OMC_STOP; // R06
                end else if (halt_exec_i && !ctrl_ff[omc_pkg::CTRL_WDG_BIT]) begin
                    nxt_state = omc_pkg::OMC_HALT; // R12 R14
                end else if (wfi_exec_i) begin
                    nxt_state = omc_pkg::OMC_WFI; // R03
                end
            end
            omc_pkg::OMC_WFI: begin
                if (irq_ack_i) begin
                    nxt_state = omc_pkg::OMC_RUN; // R03
                end
            end
            omc_pkg::OMC_STOP: begin
                if ((|wakeup_line_i) || nmi_i) begin
                    nxt_state = omc_pkg::OMC_STAB; // R07
                    stop_exit = 1'b1;
                end
            end
            omc_pkg::OMC_STAB: begin
                if (stab_done) begin
                    nxt_state = omc_pkg::OMC_RUN; // R08
                end
            end
            omc_pkg::OMC_HALT: begin
                nxt_state = omc_pkg::OMC_HALT; // R13
            end
            default: begin
                nxt_state = omc_pkg::OMC_RUN;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= omc_pkg::OMC_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // ---------------------------------------------------------------
    // clock gating outputs
    // ---------------------------------------------------------------
    always_comb begin
        nxt_clk_en   = '0;
        nxt_osc_stop = 1'b0;
        nxt_pll_sel  = 1'b0;
        case (nxt_state)
            omc_pkg::OMC_RUN: begin
                nxt_clk_en.cpu = tick; // R01 R02
                nxt_clk_en.per = tick; // R01 R02
                nxt_pll_sel    = nxt_ctrl[omc_pkg::CTRL_PLL_BIT]; // R01
            end
            omc_pkg::OMC_WFI: begin
                nxt_clk_en.per = tick; // R04 R05
                nxt_pll_sel    = nxt_ctrl[omc_pkg::CTRL_PLL_BIT];
            end
            omc_pkg::OMC_STOP: begin
                nxt_osc_stop = 1'b1; // R06
            end
            omc_pkg::OMC_STAB: begin
                nxt_osc_stop = 1'b0; // R10
            end
            omc_pkg::OMC_HALT: begin
                nxt_osc_stop = 1'b1; // R12
            end
            default: begin
                nxt_osc_stop = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clk_en_ff   <= '0;
            osc_stop_ff <= 1'b0;
            pll_sel_ff  <= 1'b0;
        end else begin
            clk_en_ff   <= nxt_clk_en;
            osc_stop_ff <= nxt_osc_stop;
            pll_sel_ff  <= nxt_pll_sel;
        end
    end

    assign clk_en_o   = clk_en_ff;
    assign osc_stop_o = osc_stop_ff;
    assign pll_sel_o  = pll_sel_ff;
    assign wb_dat_o   = rdat_ff;
    assign wb_ack_o   = ack_ff;

endmodule

// ===== testbench/omc_top_assertions.sv
`timescale 1ns/1ps
module omc_top_assertions #(
    parameter int unsigned STAB_CYCLES = omc_pkg::STAB_CYCLES,
    parameter int unsigned WAKE_LINES  = omc_pkg::WAKE_LINES
) (
    // clock and reset
    input wire logic                  clk_i,
    input wire logic                  rst_i,
    // bus handshake
    input wire logic                  wb_cyc_i,
    input wire logic                  wb_stb_i,
    input wire logic                  wb_ack_o,
    // events and wake
    input wire logic                  wfi_exec_i,
    input wire logic                  halt_exec_i,
    input wire logic                  irq_ack_i,
    input wire logic                  nmi_i,
    input wire logic [WAKE_LINES-1:0] wakeup_line_i,
    input wire logic                  osc_running_i,
    // clock control
    input wire omc_pkg::omc_clk_en_t  clk_en_o,
    input wire logic                  osc_stop_o,
    input wire logic                  pll_sel_o
);
    // ------------------------------------------------------------
    // halt tracking and restart count
    // ------------------------------------------------------------
    logic        hx_ff, hlt_ff, arm_ff, halted;
    logic        nxt_hlt, nxt_arm;
    logic [31:0] cnt_ff, nxt_cnt;
    assign halted = hlt_ff | (osc_stop_o & hx_ff);
    always_comb begin
        nxt_hlt = halted;
        nxt_arm = arm_ff;
        nxt_cnt = cnt_ff;
        if (osc_stop_o) begin
            nxt_arm = !halted;
            nxt_cnt = 32'h0;
        end else if (clk_en_o != 2'h0) begin
            nxt_arm = 1'h0;
        end else if (arm_ff && osc_running_i) begin
            nxt_cnt = cnt_ff + 32'h1;
        end
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hx_ff  <= 1'h0;
            hlt_ff <= 1'h0;
            arm_ff <= 1'h0;
            cnt_ff <= 32'h0;
        end else begin
            hx_ff  <= halt_exec_i;
            hlt_ff <= nxt_hlt;
            arm_ff <= nxt_arm;
            cnt_ff <= nxt_cnt;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack not one cycle after request");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_stop_gate: assert property (osc_stop_o |-> clk_en_o == 2'h0)
        else $error("clock enable while oscillator stopped");
    chk_wake_exit: assert property (osc_stop_o && !halted && (|wakeup_line_i || nmi_i) |=> !osc_stop_o)
        else $error("wake source did not end stop");
    chk_halt_stay: assert property (halted |=> osc_stop_o)
        else $error("halt left without reset");
    chk_exit_nopll: assert property ($fell(osc_stop_o) |-> !pll_sel_o)
        else $error("pll selected at stop exit");
    chk_stab_min: assert property (arm_ff && clk_en_o != 2'h0 |-> cnt_ff >= STAB_CYCLES)
        else $error("clocks resumed before stabilisation count");
    chk_wfi_gate: assert property (wfi_exec_i && !halt_exec_i && !irq_ack_i && clk_en_o.cpu
        |=> !clk_en_o.cpu ##[0:16] clk_en_o.per)
        else $error("wait state clocking wrong");
    cover property ($rose(osc_stop_o));
    cover property ($fell(osc_stop_o));
    cover property (wfi_exec_i && clk_en_o.cpu);
endmodule

bind omc_top omc_top_assertions #(.STAB_CYCLES(STAB_CYCLES), .WAKE_LINES(WAKE_LINES)) u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
    .wfi_exec_i(wfi_exec_i), .halt_exec_i(halt_exec_i), .irq_ack_i(irq_ack_i), .nmi_i(nmi_i),
    .wakeup_line_i(wakeup_line_i), .osc_running_i(osc_running_i), .clk_en_o(clk_en_o),
    .osc_stop_o(osc_stop_o), .pll_sel_o(pll_sel_o));

// ===== testbench/omc_osc_model.sv
`timescale 1ns/1ps
module omc_osc_model #(
    parameter int unsigned START_DLY = 6
) (
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // oscillator
    input  wire logic osc_stop_i,
    output logic      osc_running_o
);
    int unsigned wait_ff;
    // oscillation begins some cycles after the stop is lifted
    always @(posedge clk_i) begin
        if (rst_i || osc_stop_i) begin
            wait_ff       <= START_DLY;
            osc_running_o <= 1'h0;
        end else if (wait_ff != 0) begin
            wait_ff <= wait_ff - 1;
        end else begin
            osc_running_o <= 1'h1;
        end
    end
endmodule

// ===== testbench/omc_top_tb.sv
`timescale 1ns/1ps
module omc_top_tb;
    localparam int unsigned STAB_SIM = 20;
    logic                 clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [7:0]           wb_adr_i;
    logic [31:0]          wb_dat_i, wb_dat_o, rd;
    logic                 wfi_exec_i, halt_exec_i, irq_ack_i, nmi_i, osc_running_i;
    logic [15:0]          wakeup_line_i;
    omc_pkg::omc_clk_en_t clk_en_o;
    logic                 osc_stop_o, pll_sel_o;
    int                   error_cnt, checks_done;

    omc_top #(.STAB_CYCLES(STAB_SIM)) dut (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
        .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wfi_exec_i(wfi_exec_i), .halt_exec_i(halt_exec_i), .irq_ack_i(irq_ack_i),
        .nmi_i(nmi_i), .wakeup_line_i(wakeup_line_i), .osc_running_i(osc_running_i),
        .clk_en_o(clk_en_o), .osc_stop_o(osc_stop_o), .pll_sel_o(pll_sel_o));
    omc_osc_model u_osc (.clk_i(clk_i), .rst_i(rst_i), .osc_stop_i(osc_stop_o), .osc_running_o(osc_running_i));

    initial begin
        clk_i = 1'h0;
        forever #2.5 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        wb_cyc_i <= 1'h1;
        wb_stb_i <= 1'h1;
        wb_we_i  <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 50);
        rd = wb_dat_o;
        wb_cyc_i <= 1'h0;
        wb_stb_i <= 1'h0;
        if (n >= 50) begin
            error_cnt++;
            tally_and_finish();
        end
        @(posedge clk_i);
    endtask
    task automatic cnt_en(input int cyc, output int c, output int p);
        c = 0;
        p = 0;
        repeat (cyc) begin
            @(posedge clk_i);
            c += int'(clk_en_o.cpu === 1'h1);
            p += int'(clk_en_o.per === 1'h1);
        end
    endtask
    task automatic pulse_wfi();
        wfi_exec_i <= 1'h1;
        @(posedge clk_i);
        wfi_exec_i <= 1'h0;
    endtask
    task automatic pulse_irq();
        irq_ack_i <= 1'h1;
        @(posedge clk_i);
        irq_ack_i <= 1'h0;
    endtask
    task automatic do_reset();
        rst_i <= 1'h1;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'h0;
        repeat (4) @(posedge clk_i);
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_run();
        int c, p;
        chk(pll_sel_o, 1);
        cnt_en(16, c, p);
        chk(c, 16);
        chk(p, 16);
        wb_xfer(1'h0, omc_pkg::ADDR_CTRL, 32'h0);
        chk(rd, omc_pkg::CTRL_RST);
        wb_xfer(1'h1, 8'h20, 32'hFFFF_FFFF);
        wb_xfer(1'h0, 8'h20, 32'h0);
        chk(rd, 32'h0);
    endtask
    task automatic t_slow();
        int c, p;
        wb_xfer(1'h1, omc_pkg::ADDR_CTRL, 32'h0000_0303);
        cnt_en(16, c, p);
        chk(c, 4);
        chk(p, 4);
        pulse_wfi();
        cnt_en(16, c, p);
        chk(c, 0);
        chk(p, 4);
        pulse_irq();
        cnt_en(8, c, p);
        chk(c, 2);
        wb_xfer(1'h1, omc_pkg::ADDR_CTRL, 32'h0000_0102);
    endtask
    task automatic t_wfi();
        int c, p;
        pulse_wfi();
        cnt_en(8, c, p);
        chk(c, 0);
        chk(p, 8);
        pulse_irq();
        cnt_en(4, c, p);
        chk(c, 4);
    endtask
    task automatic stop_seq();
        wb_xfer(1'h1, omc_pkg::ADDR_STOP, 32'h0000_0001);
        wb_xfer(1'h1, omc_pkg::ADDR_STOP, 32'h0000_0000);
        wb_xfer(1'h1, omc_pkg::ADDR_STOP, 32'h0000_0001);
    endtask
    task automatic t_stop();
        int n;
        logic [31:0] w0;
        wb_xfer(1'h1, omc_pkg::ADDR_CTRL, 32'h0000_0106);
        nmi_i <= 1'h1;
        stop_seq();
        chk(osc_stop_o, 0);
        nmi_i <= 1'h0;
        for (int k = 0; k <= 16; k++) begin
            stop_seq();
            chk(osc_stop_o, 1);
            wb_xfer(1'h0, omc_pkg::ADDR_WDG, 32'h0);
            w0 = rd;
            repeat (6) @(posedge clk_i);
            wb_xfer(1'h0, omc_pkg::ADDR_WDG, 32'h0);
            chk(rd, w0);
            if (k < 16) wakeup_line_i <= 16'h0001 << k;
            else nmi_i <= 1'h1;
            repeat (2) @(posedge clk_i);
            wakeup_line_i <= 16'h0;
            nmi_i <= 1'h0;
            n = 0;
            while (clk_en_o.cpu !== 1'h1 && n < 500) begin
                @(posedge clk_i);
                n++;
            end
            chk(n >= STAB_SIM && n < 500, 1);
            chk(pll_sel_o, 0);
            wb_xfer(1'h0, omc_pkg::ADDR_CTRL, 32'h0);
            chk(rd, 32'h0000_0104);
            wb_xfer(1'h0, omc_pkg::ADDR_WDG, 32'h0);
            chk(rd > w0, 1);
            wb_xfer(1'h0, omc_pkg::ADDR_WAKE, 32'h0);
            chk(rd, (k < 16) ? (32'h2 << k) - 32'h1 : 32'hFFFF);
            wb_xfer(1'h1, omc_pkg::ADDR_CTRL, 32'h0000_0106);
            chk(pll_sel_o, 1);
        end
    endtask
    task automatic t_halt();
        int c, p;
        halt_exec_i <= 1'h1;
        @(posedge clk_i);
        halt_exec_i <= 1'h0;
        cnt_en(4, c, p);
        chk(c, 4);
        chk(osc_stop_o, 0);
        wb_xfer(1'h1, omc_pkg::ADDR_CTRL, 32'h0000_0102);
        halt_exec_i <= 1'h1;
        @(posedge clk_i);
        halt_exec_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        chk(osc_stop_o, 1);
        chk(clk_en_o, 2'h0);
        wakeup_line_i <= 16'hFFFF;
        nmi_i <= 1'h1;
        irq_ack_i <= 1'h1;
        repeat (10) @(posedge clk_i);
        chk(osc_stop_o, 1);
        chk(clk_en_o, 2'h0);
        wakeup_line_i <= 16'h0;
        nmi_i <= 1'h0;
        irq_ack_i <= 1'h0;
        do_reset();
        chk(osc_stop_o, 0);
        chk(clk_en_o, 2'h3);
    endtask

    initial begin
        error_cnt = 0;
        checks_done = 0;
        rst_i = 1'h1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wfi_exec_i, halt_exec_i, irq_ack_i, nmi_i} = 7'h0;
        wb_adr_i = 8'h0;
        wb_dat_i = 32'h0;
        wakeup_line_i = 16'h0;
        do_reset();
        t_run();
        t_slow();
        t_wfi();
        t_stop();
        t_halt();
        tally_and_finish();
    end
endmodule
